/* File: design/burst_addr_counter.sv */
// Per-port burst address counter with clear, load, advance and hold
`timescale 1ns/100ps
`default_nettype none

module burst_addr_counter
   import sram_burst_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_8K
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic port_edge_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic address_strobe_n_in,
   input wire logic count_advance_n_in,
   input wire logic counter_clear_n_in,
   output logic [ADDR_W-1:0] count_out,
   output logic [ADDR_W-1:0] next_count_out
);

   count_op_e op;

   // Clear beats load, load beats advance; chip selects play no part
   always_comb begin
      if (!counter_clear_n_in) begin
         op = COUNT_CLEAR; // [R12] [R23]
      end else if (!address_strobe_n_in) begin
         op = COUNT_LOAD; // [R09] [R11]
      end else if (!count_advance_n_in) begin
         op = COUNT_ADVANCE; // [R10]
      end else begin
         op = COUNT_HOLD; // [R22]
      end
   end

   // Next value doubles as this edge's access address
   always_comb begin
      case (op)
         COUNT_CLEAR: next_count_out = ADDR_W'(COUNT_CLEAR_VALUE); // [R12]
         COUNT_LOAD: next_count_out = addr_in; // [R09]
         COUNT_ADVANCE: next_count_out = count_out + ADDR_W'(COUNT_STEP); // [R13] wraps
         COUNT_HOLD: next_count_out = count_out; // [R22]
         default: next_count_out = count_out;
      endcase
   end

   // Counter register moves only on a port clock edge
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         count_out <= '0;
      end else if (port_edge_in) begin
         count_out <= next_count_out; // [R17]
      end
   end

   chk_clear_to_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R12]
      port_edge_in && !counter_clear_n_in |=> count_out == '0)
      else $error("counter not cleared");
   chk_load_address: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R09]
      port_edge_in && counter_clear_n_in && !address_strobe_n_in
      |=> count_out == $past(addr_in))
      else $error("counter not loaded");
   chk_advance_wrap: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R13]
      port_edge_in && counter_clear_n_in && address_strobe_n_in && !count_advance_n_in
      |=> count_out == ADDR_W'($past(count_out) + ADDR_W'(COUNT_STEP)))
      else $error("counter did not advance");
   chk_hold_steady: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R22]
      (!port_edge_in || (counter_clear_n_in && address_strobe_n_in && count_advance_n_in))
      |=> $stable(count_out))
      else $error("counter moved while held");

endmodule // burst_addr_counter

`default_nettype wire

/* File: design/port_read_stage.sv */
// Per-port read output stage: flow-through or pipelined data and lane drive
`timescale 1ns/100ps
`default_nettype none

module port_read_stage
   import sram_burst_pkg::*;
#(
   parameter int WORD_W = DATA_W
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic port_edge_in,
   input wire logic selected_in,
   input wire logic read_in,
   input wire logic pipe_in,
   input wire logic [NUM_LANES-1:0] lane_en_in,
   input wire logic output_enable_n_in,
   input wire logic [WORD_W-1:0] mem_data_in,
   output logic [WORD_W-1:0] data_out,
   output logic [NUM_LANES-1:0] lane_oe_out,
   output logic power_down_out
);

   logic [WORD_W-1:0] flow_data;
   logic [NUM_LANES-1:0] flow_drive;
   logic [NUM_LANES-1:0] drive;
   logic [NUM_LANES-1:0] next_drive;

   // Lanes that this edge's access would drive
   assign next_drive = (selected_in && read_in) ? lane_en_in : '0; // [R06] [R14]

   // First stage: word read at the capture edge
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         flow_data <= '0;
         flow_drive <= '0;
      end else if (port_edge_in) begin
         flow_data <= mem_data_in;
         flow_drive <= next_drive;
      end
   end

   // Output register: pipe mode takes the held stage one edge later
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         data_out <= '0;
         drive <= '0;
      end else if (port_edge_in) begin
         data_out <= pipe_in ? flow_data : mem_data_in; // [R04] [R21]
         drive <= pipe_in ? flow_drive : next_drive; // [R08]
      end
   end

   // Deselected ports idle their circuitry until selected again
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         power_down_out <= 1'b1;
      end else if (port_edge_in) begin
         power_down_out <= !selected_in; // [R07]
      end
   end

   // Output enable is not clocked, so it gates the drivers directly
   assign lane_oe_out = drive & {NUM_LANES{!output_enable_n_in}}; // [R15] [R24]

   // The edge after a deselect still shows the older access; the one after that stays quiet
   chk_pipe_wakeup: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R08]
      port_edge_in && pipe_in && !selected_in ##1 port_edge_in && pipe_in |=> drive == '0)
      else $error("pipe drove right after deselect");
   chk_flow_data: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R04]
      port_edge_in && !pipe_in |=> data_out == $past(mem_data_in))
      else $error("flow data mismatch");
   chk_pipe_latency: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R21]
      port_edge_in ##1 port_edge_in && pipe_in
      |=> data_out == $past(mem_data_in, 2))
      else $error("pipe data not one edge late");
   chk_oe_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R24]
      output_enable_n_in |-> lane_oe_out == '0)
      else $error("lanes driven with output enable high");

endmodule // port_read_stage

`default_nettype wire

/* File: design/sram_burst_pkg.sv */
// Shared constants and types for the dual-port burst SRAM
package sram_burst_pkg;

   // ************************************************************
   // Array shape
   // ************************************************************
   localparam int ADDR_W_4K = 12;
   localparam int ADDR_W_8K = 13;
   localparam int DATA_W = 18;
   localparam int LANE_W = 9;
   localparam int NUM_LANES = 2;
   localparam int LOW_LANE = 0;
   localparam int HIGH_LANE = 1;

   // ************************************************************
   // Port indices
   // ************************************************************
   localparam int NUM_PORTS = 2;
   localparam int PORT_LEFT = 0;
   localparam int PORT_RIGHT = 1;

   // ************************************************************
   // Burst counter
   // ************************************************************
   localparam int COUNT_CLEAR_VALUE = 0;
   localparam int COUNT_STEP = 1;

   // Counter action chosen at each port clock edge
   typedef enum logic [1:0] {
      COUNT_CLEAR,
      COUNT_LOAD,
      COUNT_ADVANCE,
      COUNT_HOLD
   } count_op_e;

endpackage

/* File: design/sync_dual_port_sram_burst.sv */
// Top: two independent burst ports sharing one byte-lane-writable array
//
// What this block does
// [R01] Two ports work independently and together, each reaching any word.
// [R02] Array is 4K or 8K words, each 18 bits wide.
// [R03] Same-word writes from both ports together leave an undefined value.
// [R04] Pipelined mode registers read data; flow-through skips that register.
// [R05] Outside party drives mode select high for pipelined, low for flow-through.
// [R06] Port selected only with low-active select low and high-active select high.
// [R07] A deselected port powers down its internal circuitry for that cycle.
// [R08] Pipelined port needs one selected cycle before outputs drive again.
// [R09] Address strobe low loads the burst counter with the presented address.
// [R10] Count-advance low increments the counter each edge, one word per cycle.
// [R11] Count-advance ignored while address strobe or counter clear is low.
// [R12] Counter clear low zeroes the counter, over strobe and advance.
// [R13] Counter spans the array and wraps from last word to zero.
// [R14] Low and high byte selects gate writes and drives of their lanes.
// [R15] Read lane drives only while its byte select and output enable are low.
// [R16] Outside party drives read-not-write low to write, high to read.
// [R17] Address, control and write data are captured on the port edge.
// [R18] Write strobe is self-timed and completes within one cycle.
// [R19] Port clock free-running or gated; pipelined rate at most 100 MHz.
// [R20] Outside party should hold address strobe low for single accesses.
// [R21] Pipelined read data appears one port cycle after flow-through.
// [R22] All three counter controls high holds the counter, ignoring address.
// [R23] Counter actions work regardless of either chip select.
// [R24] Output enable acts on the data drivers without a clock edge.
// [R25] Counter is as wide as the address, 12 or 13 bits.
`timescale 1ns/100ps
`default_nettype none

module sync_dual_port_sram_burst
   import sram_burst_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_8K
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Left port
   input wire logic left_port_edge_in,
   input wire logic [ADDR_W-1:0] left_addr_in,
   input wire logic left_address_strobe_n_in,
   input wire logic left_count_advance_n_in,
   input wire logic left_counter_clear_n_in,
   input wire logic left_chip_select_low_active_in,
   input wire logic left_chip_select_high_active_in,
   input wire logic left_read_not_write_in,
   input wire logic left_low_byte_select_n_in,
   input wire logic left_high_byte_select_n_in,
   input wire logic left_output_enable_n_in,
   input wire logic left_flow_or_pipe_select_in,
   input wire logic [DATA_W-1:0] left_data_in,
   output logic [DATA_W-1:0] left_data_out,
   output logic [NUM_LANES-1:0] left_lane_oe_out,
   output logic left_power_down_out,
   // Right port
   input wire logic right_port_edge_in,
   input wire logic [ADDR_W-1:0] right_addr_in,
   input wire logic right_address_strobe_n_in,
   input wire logic right_count_advance_n_in,
   input wire logic right_counter_clear_n_in,
   input wire logic right_chip_select_low_active_in,
   input wire logic right_chip_select_high_active_in,
   input wire logic right_read_not_write_in,
   input wire logic right_low_byte_select_n_in,
   input wire logic right_high_byte_select_n_in,
   input wire logic right_output_enable_n_in,
   input wire logic right_flow_or_pipe_select_in,
   input wire logic [DATA_W-1:0] right_data_in,
   output logic [DATA_W-1:0] right_data_out,
   output logic [NUM_LANES-1:0] right_lane_oe_out,
   output logic right_power_down_out
);

   // ************************************************************
   // Storage
   // ************************************************************
   localparam int DEPTH = 1 << ADDR_W; // [R02] [R25]

   logic [DATA_W-1:0] mem [DEPTH];

   // ************************************************************
   // Port gathering
   // ************************************************************
   // Both ports are folded into arrays so one loop serves them
   logic port_edge [NUM_PORTS];
   logic [ADDR_W-1:0] addr [NUM_PORTS];
   logic address_strobe_n [NUM_PORTS];
   logic count_advance_n [NUM_PORTS];
   logic counter_clear_n [NUM_PORTS];
   logic chip_select_low_active [NUM_PORTS];
   logic chip_select_high_active [NUM_PORTS];
   logic read_not_write [NUM_PORTS];
   logic [NUM_LANES-1:0] lane_en [NUM_PORTS];
   logic output_enable_n [NUM_PORTS];
   logic flow_or_pipe_select [NUM_PORTS];
   logic [DATA_W-1:0] wr_data [NUM_PORTS];
   logic [DATA_W-1:0] rd_data [NUM_PORTS];
   logic [DATA_W-1:0] port_data [NUM_PORTS];
   logic [NUM_LANES-1:0] port_lane_oe [NUM_PORTS];
   logic port_power_down [NUM_PORTS];
   logic [ADDR_W-1:0] count [NUM_PORTS];
   logic [ADDR_W-1:0] access_addr [NUM_PORTS];
   logic selected [NUM_PORTS];
   logic write_now [NUM_PORTS];

   // Left port inputs
   assign port_edge[PORT_LEFT] = left_port_edge_in;
   assign addr[PORT_LEFT] = left_addr_in;
   assign address_strobe_n[PORT_LEFT] = left_address_strobe_n_in;
   assign count_advance_n[PORT_LEFT] = left_count_advance_n_in;
   assign counter_clear_n[PORT_LEFT] = left_counter_clear_n_in;
   assign chip_select_low_active[PORT_LEFT] = left_chip_select_low_active_in;
   assign chip_select_high_active[PORT_LEFT] = left_chip_select_high_active_in;
   assign read_not_write[PORT_LEFT] = left_read_not_write_in;
   assign lane_en[PORT_LEFT][LOW_LANE] = !left_low_byte_select_n_in;
   assign lane_en[PORT_LEFT][HIGH_LANE] = !left_high_byte_select_n_in;
   assign output_enable_n[PORT_LEFT] = left_output_enable_n_in;
   assign flow_or_pipe_select[PORT_LEFT] = left_flow_or_pipe_select_in;
   assign wr_data[PORT_LEFT] = left_data_in;

   // Right port inputs
   assign port_edge[PORT_RIGHT] = right_port_edge_in;
   assign addr[PORT_RIGHT] = right_addr_in;
   assign address_strobe_n[PORT_RIGHT] = right_address_strobe_n_in;
   assign count_advance_n[PORT_RIGHT] = right_count_advance_n_in;
   assign counter_clear_n[PORT_RIGHT] = right_counter_clear_n_in;
   assign chip_select_low_active[PORT_RIGHT] = right_chip_select_low_active_in;
   assign chip_select_high_active[PORT_RIGHT] = right_chip_select_high_active_in;
   assign read_not_write[PORT_RIGHT] = right_read_not_write_in;
   assign lane_en[PORT_RIGHT][LOW_LANE] = !right_low_byte_select_n_in;
   assign lane_en[PORT_RIGHT][HIGH_LANE] = !right_high_byte_select_n_in;
   assign output_enable_n[PORT_RIGHT] = right_output_enable_n_in;
   assign flow_or_pipe_select[PORT_RIGHT] = right_flow_or_pipe_select_in;
   assign wr_data[PORT_RIGHT] = right_data_in;

   // Outputs; data and power-down come from stage registers
   assign left_data_out = port_data[PORT_LEFT];
   assign left_lane_oe_out = port_lane_oe[PORT_LEFT];
   assign left_power_down_out = port_power_down[PORT_LEFT];
   assign right_data_out = port_data[PORT_RIGHT];
   assign right_lane_oe_out = port_lane_oe[PORT_RIGHT];
   assign right_power_down_out = port_power_down[PORT_RIGHT];

   // ************************************************************
   // Per-port address path and read stage
   // ************************************************************
   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         // Both selects must agree; anything else deselects
         assign selected[p] = !chip_select_low_active[p] && chip_select_high_active[p]; // [R06]
         assign write_now[p] = port_edge[p] && selected[p] && !read_not_write[p]; // [R16]

         // Counter ignores chip selects entirely
         burst_addr_counter #(
            .ADDR_W(ADDR_W)
         ) u_counter (
            .sys_clk_in(sys_clk_in),
            .rst_in(rst_in),
            .port_edge_in(port_edge[p]),
            .addr_in(addr[p]),
            .address_strobe_n_in(address_strobe_n[p]),
            .count_advance_n_in(count_advance_n[p]),
            .counter_clear_n_in(counter_clear_n[p]),
            .count_out(count[p]),
            .next_count_out(access_addr[p])
         ); // [R23] [R25]

         // Word at this edge's address; the array is shared by both ports
         assign rd_data[p] = mem[access_addr[p]]; // [R01]

         port_read_stage #(
            .WORD_W(DATA_W)
         ) u_read (
            .sys_clk_in(sys_clk_in),
            .rst_in(rst_in),
            .port_edge_in(port_edge[p]),
            .selected_in(selected[p]),
            .read_in(read_not_write[p]),
            .pipe_in(flow_or_pipe_select[p]), // [R05]
            .lane_en_in(lane_en[p]),
            .output_enable_n_in(output_enable_n[p]),
            .mem_data_in(rd_data[p]),
            .data_out(port_data[p]),
            .lane_oe_out(port_lane_oe[p]),
            .power_down_out(port_power_down[p])
         );

         chk_deselect_quiet: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R06]
            port_edge[p] && !selected[p] && !flow_or_pipe_select[p]
            |=> port_lane_oe[p] == '0)
            else $error("deselected port still drives");
         chk_write_no_drive: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R15]
            port_edge[p] && !read_not_write[p] && !flow_or_pipe_select[p]
            |=> port_lane_oe[p] == '0)
            else $error("port drives during write");
         chk_power_down: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R07]
            port_edge[p] |=> port_power_down[p] == !$past(selected[p]))
            else $error("power-down flag wrong");
         chk_access_wrap: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R13]
            count[p] == ADDR_W'(DEPTH - 1) && counter_clear_n[p] && address_strobe_n[p]
            && !count_advance_n[p] |-> access_addr[p] == '0)
            else $error("counter did not wrap to zero");
         chk_clear_priority: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R11]
            !counter_clear_n[p] || !address_strobe_n[p]
            |-> access_addr[p] != ADDR_W'(count[p] + ADDR_W'(COUNT_STEP))
            || access_addr[p] == (counter_clear_n[p] ? addr[p] : '0))
            else $error("advance acted while strobe or clear low");
      end
   endgenerate

   // ************************************************************
   // Array writes
   // ************************************************************
   // Write lands in the capture cycle itself, so no later port edge is
   // needed to finish it. Two ports hitting one word in one cycle are
   // resolved by loop order here; callers must treat the word as unknown.
   always_ff @(posedge sys_clk_in) begin
      for (int wp = 0; wp < NUM_PORTS; wp++) begin
         for (int ln = 0; ln < NUM_LANES; ln++) begin
            if (write_now[wp] && lane_en[wp][ln]) begin
               mem[access_addr[wp]][ln*LANE_W +: LANE_W] <= wr_data[wp][ln*LANE_W +: LANE_W]; // [R14] [R17] [R18] [R03]
            end
         end
      end
   end

   // ************************************************************
   // Write checks on the array
   // ************************************************************
   // Right port not writing so the left-port word can be judged alone
   chk_write_lands: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R18]
      write_now[PORT_LEFT] && lane_en[PORT_LEFT] == '1 && !write_now[PORT_RIGHT]
      |=> mem[$past(access_addr[PORT_LEFT])] == $past(wr_data[PORT_LEFT]))
      else $error("write did not complete in one cycle");
   chk_lane_guard: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R14]
      write_now[PORT_LEFT] && !lane_en[PORT_LEFT][HIGH_LANE] && !write_now[PORT_RIGHT]
      |=> mem[$past(access_addr[PORT_LEFT])][HIGH_LANE*LANE_W +: LANE_W]
      == $past(rd_data[PORT_LEFT][HIGH_LANE*LANE_W +: LANE_W]))
      else $error("disabled lane was written");
   chk_right_writes: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R01]
      write_now[PORT_RIGHT] && lane_en[PORT_RIGHT] == '1 && !write_now[PORT_LEFT]
      |=> mem[$past(access_addr[PORT_RIGHT])] == $past(wr_data[PORT_RIGHT]))
      else $error("right port write lost");

endmodule // sync_dual_port_sram_burst

`default_nettype wire

/* File: test/port_master.sv */
// Memory-controller model driving one port of the dual-port SRAM
`timescale 1ns/100ps
`default_nettype none

module port_master
   import sram_burst_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_4K
) (
   input wire logic sys_clk_in,
   output logic edge_out,
   output logic [ADDR_W-1:0] addr_out,
   output logic [9:0] ctl_out,
   output logic [DATA_W-1:0] wdata_out
);
   // ****************************************
   // Idle: port clock stopped, high-active chip select low so the port is deselected
   // ****************************************
   initial begin
      edge_out = 1'b0;
      addr_out = '0;
      ctl_out = 10'h1EE; // output enable low until a test raises it
      wdata_out = '0;
   end

   // One access, changed just after an edge and held over one port edge
   task automatic acc(input logic [8:0] c, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
      edge_out = 1'b1;
      addr_out = a;
      ctl_out[8:0] = c;
      // Released data lines flip so a stale value cannot pass
      wdata_out = c[3] ? ~wdata_out : d;
      @(posedge sys_clk_in);
      #1;
   endtask

   // Gated port clock: no edge this cycle
   task automatic idle();
      edge_out = 1'b0;
      @(posedge sys_clk_in);
      #1;
   endtask

   // Output enable moves with no clock
   task automatic oe(input logic v);
      ctl_out[9] = v;
   endtask
endmodule // port_master

`default_nettype wire

/* File: test/sync_dual_port_sram_burst_tb.sv */
// Self-checking bench for the dual-port burst SRAM against a behavioural model
`timescale 1ns/100ps
`default_nettype none

module sync_dual_port_sram_burst_tb
   import sram_burst_pkg::*;
;
   // ****************************************
   // Signals and model state
   // ****************************************
   localparam logic [8:0] RD = 9'h0D8;
   localparam logic [8:0] WR = 9'h0D0;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic l_edge, r_edge, l_pd, r_pd;
   logic [11:0] l_addr, r_addr;
   logic [9:0] l_ctl, r_ctl;
   logic [DATA_W-1:0] l_wd, r_wd, l_rd, r_rd;
   logic [1:0] l_oe, r_oe;
   int miscompares = 0;
   int checked = 0;
   logic [17:0] mem [int];
   logic [11:0] cnt [2] = '{12'h000, 12'h000};
   logic [1:0] pv_oe [2], vis_oe [2];
   logic [17:0] pv_d [2], vis_d [2];
   logic pv_k [2], vis_k [2];
   logic lp [2] = '{1'b0, 1'b0};
   logic [8:0] seq [10] = '{RD, RD ^ 9'h180, RD ^ 9'h180, RD ^ 9'h180, RD ^ 9'h180 | 9'h020,
      RD ^ 9'h180, RD ^ 9'h100, RD ^ 9'h080, RD ^ 9'h040, RD ^ 9'h1C0};
   logic [11:0] sadr [10] = '{12'hFFE, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000,
      12'h000, 12'hFFF, 12'hFFF, 12'h000};

   // 200 MHz clock
   always #2.5 sys_clk = ~sys_clk;

   port_master #(.ADDR_W(12)) left_m (.sys_clk_in(sys_clk), .edge_out(l_edge),
      .addr_out(l_addr), .ctl_out(l_ctl), .wdata_out(l_wd));
   port_master #(.ADDR_W(12)) right_m (.sys_clk_in(sys_clk), .edge_out(r_edge),
      .addr_out(r_addr), .ctl_out(r_ctl), .wdata_out(r_wd));

   // 4K variant keeps the burst wrap short
   sync_dual_port_sram_burst #(.ADDR_W(12)) sync_dual_port_sram_burst_i (
      .sys_clk_in(sys_clk), .rst_in(rst),
      .left_port_edge_in(l_edge), .left_addr_in(l_addr),
      .left_address_strobe_n_in(l_ctl[8]), .left_count_advance_n_in(l_ctl[7]),
      .left_counter_clear_n_in(l_ctl[6]), .left_chip_select_low_active_in(l_ctl[5]),
      .left_chip_select_high_active_in(l_ctl[4]), .left_read_not_write_in(l_ctl[3]),
      .left_low_byte_select_n_in(l_ctl[2]), .left_high_byte_select_n_in(l_ctl[1]),
      .left_output_enable_n_in(l_ctl[9]), .left_flow_or_pipe_select_in(l_ctl[0]),
      .left_data_in(l_wd), .left_data_out(l_rd), .left_lane_oe_out(l_oe),
      .left_power_down_out(l_pd),
      .right_port_edge_in(r_edge), .right_addr_in(r_addr),
      .right_address_strobe_n_in(r_ctl[8]), .right_count_advance_n_in(r_ctl[7]),
      .right_counter_clear_n_in(r_ctl[6]), .right_chip_select_low_active_in(r_ctl[5]),
      .right_chip_select_high_active_in(r_ctl[4]), .right_read_not_write_in(r_ctl[3]),
      .right_low_byte_select_n_in(r_ctl[2]), .right_high_byte_select_n_in(r_ctl[1]),
      .right_output_enable_n_in(r_ctl[9]), .right_flow_or_pipe_select_in(r_ctl[0]),
      .right_data_in(r_wd), .right_data_out(r_rd), .right_lane_oe_out(r_oe),
      .right_power_down_out(r_pd));

   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One access on port p, the other port idle; model then compare
   task automatic do_acc(input int p, input logic [8:0] c, input logic [11:0] a,
      input logic [17:0] d);
      logic sel, ck;
      logic [1:0] en, co;
      logic [17:0] w, m, cd;
      fork
         if (p == 0) left_m.acc(c, a, d); else left_m.idle();
         if (p == 1) right_m.acc(c, a, d); else right_m.idle();
      join
      cnt[p] = !c[6] ? 12'h000 : !c[8] ? a : !c[7] ? cnt[p] + 12'h001 : cnt[p];
      sel = !c[5] && c[4];
      en = {!c[1], !c[2]};
      if (sel && !c[3]) begin
         w = mem.exists(cnt[p]) ? mem[cnt[p]] : d;
         mem[cnt[p]] = {en[1] ? d[17:9] : w[17:9], en[0] ? d[8:0] : w[8:0]};
      end
      co = (sel && c[3]) ? en : 2'b00;
      ck = mem.exists(cnt[p]);
      cd = ck ? mem[cnt[p]] : 18'h00000;
      // Pipelined ports show the previous access
      vis_oe[p] = c[0] ? pv_oe[p] : co;
      vis_d[p] = c[0] ? pv_d[p] : cd;
      vis_k[p] = c[0] ? pv_k[p] : ck;
      pv_oe[p] = co;
      pv_d[p] = cd;
      pv_k[p] = ck;
      m = {{9{vis_oe[p][1]}}, {9{vis_oe[p][0]}}};
      chk(18'(p ? r_pd : l_pd), 18'(!sel));
      // Output pipeline contents are unknown across a mode change
      if (c[0] == lp[p]) begin
         chk(18'(p ? r_oe : l_oe), 18'(vis_oe[p]));
         if (vis_k[p]) chk((p ? r_rd : l_rd) & m, vis_d[p] & m);
      end
      lp[p] = c[0];
   endtask

   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Watchdog against a hung run
   initial begin
      #20000;
      miscompares++;
      close_out();
   end

   initial begin
      int s;
      logic [11:0] a;
      logic [17:0] d;
      s = $urandom(32'hCCDF87B6);
      repeat (2) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      // Random words written by one port and read back by the other
      for (int i = 0; i < 8; i++) begin
         a = 12'($urandom);
         d = 18'($urandom);
         do_acc(i % 2, WR, a, d);
         do_acc(1 - i % 2, RD, a, 18'h00000);
      end
      // Lane selects on write and read, then output enable alone
      do_acc(0, WR | 9'h002, a, ~d);
      do_acc(1, RD, a, 18'h00000);
      do_acc(1, RD | 9'h002, a, 18'h00000);
      do_acc(1, RD | 9'h004, a, 18'h00000);
      right_m.oe(1'b1);
      do_acc(0, RD, a, 18'h00000);
      chk(18'(r_oe), 18'h00000);
      right_m.oe(1'b0);
      do_acc(0, RD, a, 18'h00000);
      chk(18'(r_oe), 18'(vis_oe[1]));
      // Writes with either select inactive are refused
      do_acc(0, WR | 9'h020, a, d);
      do_acc(0, WR ^ 9'h010, a, d);
      do_acc(1, RD, a, 18'h00000);
      // Write burst near the top of the array, wrapping through zero
      do_acc(0, WR, 12'hFFE, 18'($urandom));
      repeat (6) do_acc(0, WR ^ 9'h180, 12'($urandom), 18'($urandom));
      // Read burst with hold, strobe, clear and deselected step; flow then pipelined
      for (int k = 0; k < 2; k++) begin
         foreach (seq[i])
            do_acc(1, seq[i] | 9'(k), sadr[i] == 12'h000 ? 12'($urandom) : sadr[i],
               18'h00000);
         do_acc(1, RD | 9'(k), 12'h001, 18'h00000);
      end
      close_out();
   end
endmodule // sync_dual_port_sram_burst_tb

`default_nettype wire
